/* File: logic/pstate_transition_ctrl.sv */
// Performance-state transition controller: request resolve and V/F sequencing
// What this block does
// - Frequency comes from software-written requests, or from the autonomous choice when auto_en is set
// - Voltage follows selected frequency and active count
// - Voltage settles first, then PLL relocks
// - One shared operating point for all cores
// - Highest requested frequency among active cores wins
// - Requests accepted in any cycle; a later write to a core replaces one not yet taken
// - Requests during a transition wait for its end
// - Voltage ramp rate limited internally, glitch free
// - Software-named or hardware-chosen state modes
// - Autonomous choice bounded by min, max, window
`timescale 1ns/1ps
module pstate_transition_ctrl (
    input  wire logic                                   clk,
    input  wire logic                                   rst,
    input  wire logic [pstate_pkg::NCORES-1:0]          core_active,
    input  wire logic [pstate_pkg::NCORES-1:0]          req_we,
    input  wire logic [pstate_pkg::NCORES*8-1:0]        req_ratio,
    input  wire logic                                   auto_en,
    input  wire logic [pstate_pkg::RATIO_W-1:0]         auto_min,
    input  wire logic [pstate_pkg::RATIO_W-1:0]         auto_max,
    input  wire logic [7:0]                             activity_window,
    input  wire logic [pstate_pkg::RATIO_W-1:0]         demand_ratio,
    input  wire logic [pstate_pkg::RATIO_W-1:0]         thermal_cap,
    input  wire logic                                   pll_lock,
    output logic [pstate_pkg::RATIO_W-1:0]              pll_ratio,
    output logic                                        pll_relock,
    output logic [pstate_pkg::VID_W-1:0]                vid_code,
    output logic [pstate_pkg::RATIO_W-1:0]              applied_ratio,
    output logic                                        busy
);
    import pstate_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    ramp_if rp ();

    logic [RATIO_W-1:0] req_ff [NCORES];
    logic [RATIO_W-1:0] max_chain [NCORES+1];
    logic [CNT_W-1:0]   cnt_chain [NCORES+1];
    logic [2:0]         lock_q_ff;
    logic               lock_ok_ff;
    logic [7:0]         us_div_ff;
    logic [7:0]         win_cnt_ff;
    logic [RATIO_W-1:0] auto_ratio_ff;
    state_t             state_ff;
    state_t             nxt_state;
    logic [RATIO_W-1:0] goal_ratio_ff;
    logic [VID_W-1:0]   goal_vid_ff;
    logic [RATIO_W-1:0] pll_ratio_ff;
    logic               pll_relock_ff;
    logic [RATIO_W-1:0] cur_ratio_ff;
    logic               busy_ff;

    wire                us_tick;
    wire                win_end;
    wire [RATIO_W-1:0]  sw_target;
    wire [RATIO_W-1:0]  cool_ratio;
    wire [RATIO_W-1:0]  capped_ratio;
    wire [RATIO_W-1:0]  bounded_ratio;
    wire [RATIO_W-1:0]  target;
    wire [CNT_W-1:0]    active_cnt;
    wire [VID_W-1:0]    target_vid;
    wire                need_change;
    wire                ratio_same;

    // ****************************************
    // Request capture and resolution
    // ****************************************
    assign max_chain[0] = '0;
    assign cnt_chain[0] = '0;

    genvar gi;
    generate
        for (gi = 0; gi < NCORES; gi++) begin : g_core
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    req_ff[gi] <= RATIO_RESET;
                end else if (req_we[gi]) begin
                    req_ff[gi] <= req_ratio[gi*8 +: 8];
                end
            end
            // Idle cores take no part in the vote
            assign max_chain[gi+1] = (core_active[gi] && req_ff[gi] > max_chain[gi]) ? req_ff[gi] : max_chain[gi];
            assign cnt_chain[gi+1] = cnt_chain[gi] + CNT_W'(core_active[gi]);

            chk_req_capture: assert property (@(posedge clk) disable iff (rst)
                req_we[gi] |=> req_ff[gi] == $past(req_ratio[gi*8 +: 8]))
                else $error("software request was not captured");

            chk_max_covers: assert property (@(posedge clk) disable iff (rst)
                (core_active[gi] && !auto_en) |-> target >= req_ff[gi])
                else $error("resolved ratio below an active core request");
        end
    endgenerate

    // With no core running, hold the present point rather than drop to zero
    assign sw_target  = (core_active == '0) ? cur_ratio_ff : max_chain[NCORES];
    assign active_cnt = cnt_chain[NCORES];

    // ****************************************
    // Autonomous choice
    // ****************************************
    assign us_tick       = (us_div_ff == 8'(WIN_TICK_CYC - 1));
    assign win_end       = us_tick && (win_cnt_ff >= activity_window);
    assign cool_ratio    = (demand_ratio > thermal_cap) ? thermal_cap : demand_ratio;
    assign capped_ratio  = (cool_ratio > auto_max) ? auto_max : cool_ratio;
    // Min wins over max if software programs them crossed
    assign bounded_ratio = (capped_ratio < auto_min) ? auto_min : capped_ratio;
    assign target        = auto_en ? auto_ratio_ff : sw_target;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            us_div_ff     <= 8'h00;
            win_cnt_ff    <= 8'h00;
            auto_ratio_ff <= RATIO_RESET;
        end else begin
            us_div_ff  <= us_tick ? 8'h00 : us_div_ff + 8'h01;
            win_cnt_ff <= win_end ? 8'h00 : (us_tick ? win_cnt_ff + 8'h01 : win_cnt_ff);
            if (win_end || !auto_en) begin
                auto_ratio_ff <= bounded_ratio;
            end
        end
    end

    chk_auto_bounds: assert property (@(posedge clk) disable iff (rst)
        (auto_en && $past(auto_en) && $stable(auto_min) && $stable(auto_max) && auto_min <= auto_max
         && $past(win_end)) |-> (auto_ratio_ff >= auto_min && auto_ratio_ff <= auto_max))
        else $error("autonomous ratio outside software limits");

    // ****************************************
    // PLL lock synchroniser
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_q_ff  <= 3'h0;
            lock_ok_ff <= 1'b0;
        end else begin
            lock_q_ff <= {lock_q_ff[1:0], pll_lock};
            if (lock_q_ff[1] == lock_q_ff[2]) begin
                lock_ok_ff <= lock_q_ff[2];
            end
        end
    end

    // ****************************************
    // Transition sequencer
    // ****************************************
    // Voltage point from the single shared ratio
    assign target_vid  = vid_of(target, active_cnt);
    assign need_change = (target != cur_ratio_ff) || (target_vid != rp.level);
    assign ratio_same  = (goal_ratio_ff == cur_ratio_ff);
    assign rp.target   = goal_vid_ff;

    // Requests keep landing in req_ff while busy and are picked up in idle
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:     if (need_change) nxt_state = ST_VRAMP;
            ST_VRAMP:    if (rp.done) nxt_state = ratio_same ? ST_IDLE : ST_PLL_DROP;
            ST_PLL_DROP: if (!lock_ok_ff) nxt_state = ST_PLL_WAIT;
            ST_PLL_WAIT: if (lock_ok_ff) nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff      <= ST_IDLE;
            goal_ratio_ff <= RATIO_RESET;
            goal_vid_ff   <= VID_RESET;
            pll_ratio_ff  <= RATIO_RESET;
            pll_relock_ff <= 1'b0;
            cur_ratio_ff  <= RATIO_RESET;
            busy_ff       <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff  <= (nxt_state != ST_IDLE);
            if (state_ff == ST_IDLE && need_change) begin
                goal_ratio_ff <= target;
                goal_vid_ff   <= target_vid;
            end
            if (state_ff == ST_VRAMP && rp.done && !ratio_same) begin
                pll_ratio_ff  <= goal_ratio_ff;
                pll_relock_ff <= 1'b1;
            end
            if (state_ff == ST_PLL_WAIT && lock_ok_ff) begin
                pll_relock_ff <= 1'b0;
                cur_ratio_ff  <= goal_ratio_ff;
            end
        end
    end

    voltage_ramp u_ramp (
        .clk (clk),
        .rst (rst),
        .rp  (rp.ramp)
    );

    assign pll_ratio     = pll_ratio_ff;
    assign pll_relock    = pll_relock_ff;
    assign vid_code      = rp.level;
    assign applied_ratio = cur_ratio_ff;
    assign busy          = busy_ff;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_relock_start;
        state_ff == ST_PLL_WAIT && lock_ok_ff;
    endsequence

    sequence s_back_idle;
        state_ff == ST_IDLE && !pll_relock_ff && cur_ratio_ff == pll_ratio_ff;
    endsequence

    chk_volt_before_pll: assert property (@(posedge clk) disable iff (rst)
        $rose(pll_relock_ff) |-> $past(rp.done) && $past(state_ff == ST_VRAMP))
        else $error("PLL relock started before voltage settled");

    chk_lock_completes: assert property (@(posedge clk) disable iff (rst)
        s_relock_start |=> s_back_idle)
        else $error("lock did not complete the transition");

    chk_no_early_done: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_PLL_WAIT && !lock_ok_ff) |=> $stable(cur_ratio_ff))
        else $error("transition finished without PLL lock");

    chk_defer_busy: assert property (@(posedge clk) disable iff (rst)
        (state_ff != ST_IDLE) |=> $stable(goal_ratio_ff) && $stable(goal_vid_ff))
        else $error("new request disturbed a running transition");

    chk_idle_starts: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && need_change) |=> state_ff == ST_VRAMP && busy_ff
        && goal_ratio_ff == $past(target))
        else $error("pending request not started from idle");

    chk_vid_pairing: assert property (@(posedge clk) disable iff (rst)
        (state_ff == ST_IDLE && need_change) |=> goal_vid_ff == vid_of($past(target), $past(active_cnt)))
        else $error("voltage goal does not match ratio and core count");

endmodule : pstate_transition_ctrl

/* File: shared/pstate_pkg.sv */
// Constants, types and helpers shared by the performance-state controller
package pstate_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCORES  = 4;
    localparam int RATIO_W = 8;
    localparam int VID_W   = 8;
    localparam int CNT_W   = 3;

    // ****************************************
    // Timing (clock 100 MHz)
    // ****************************************
    localparam int CLK_NS        = 10;
    localparam int RAMP_STEP_NS  = 100;
    localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WIN_TICK_NS   = 1000;
    localparam int WIN_TICK_CYC  = WIN_TICK_NS / CLK_NS;

    // ****************************************
    // Reset values and voltage table
    // ****************************************
    localparam logic [RATIO_W-1:0] RATIO_RESET = 8'h08;
    localparam logic [VID_W-1:0]   VID_RESET   = 8'h24;
    localparam logic [VID_W-1:0]   VID_BASE    = 8'h20;
    localparam logic [VID_W-1:0]   VID_MAX     = 8'hff;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_VRAMP,
        ST_PLL_DROP,
        ST_PLL_WAIT
    } state_t;

    // Voltage code grows with ratio and with the number of running cores
    function automatic logic [VID_W-1:0] vid_of(input logic [RATIO_W-1:0] ratio, input logic [CNT_W-1:0] cnt);
        logic [VID_W:0] sum;
        sum = {1'b0, VID_BASE} + {2'b00, ratio[RATIO_W-1:1]} + {5'h00, cnt, 1'b0};
        return sum[VID_W] ? VID_MAX : sum[VID_W-1:0];
    endfunction : vid_of

endpackage : pstate_pkg

/* File: shared/ramp_if.sv */
// Carrier between the transition sequencer and the voltage ramp
`timescale 1ns/1ps
interface ramp_if;
    logic [7:0] target;
    logic [7:0] level;
    logic       done;

    modport ctrl (output target, input level, input done);
    modport ramp (input target, output level, output done);
endinterface : ramp_if

/* File: logic/voltage_ramp.sv */
// Voltage code ramp: one step per paced tick toward the target
`timescale 1ns/1ps
module voltage_ramp (
    input  wire logic clk,
    input  wire logic rst,
    ramp_if.ramp      rp
);
    import pstate_pkg::*;

    logic [7:0]         div_ff;
    logic [VID_W-1:0]   level_ff;
    logic               tick;
    logic               go_up;
    logic               go_dn;
    logic [VID_W-1:0]   nxt_level;

    assign tick      = (div_ff == 8'(RAMP_STEP_CYC - 1));
    assign go_up     = tick && (level_ff < rp.target);
    assign go_dn     = tick && (level_ff > rp.target);
    // Single-code steps keep the supply glitch-free
    assign nxt_level = go_up ? level_ff + 8'h01 : (go_dn ? level_ff - 8'h01 : level_ff);
    assign rp.level  = level_ff;
    assign rp.done   = (level_ff == rp.target);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_ff   <= 8'h00;
            level_ff <= VID_RESET;
        end else begin
            div_ff   <= tick ? 8'h00 : div_ff + 8'h01;
            level_ff <= nxt_level;
        end
    end

    chk_ramp_step_paced: assert property (@(posedge clk) disable iff (rst)
        !$past(tick) |-> $stable(level_ff))
        else $error("voltage code moved without a pacing tick");

    chk_ramp_one_code: assert property (@(posedge clk) disable iff (rst)
        $changed(level_ff) |-> (level_ff == $past(level_ff) + 8'h01) || (level_ff == $past(level_ff) - 8'h01))
        else $error("voltage code jumped by more than one step");

endmodule : voltage_ramp

/* File: verification/tb_pstate_transition_ctrl.sv */
// Self-checking testbench for the performance-state transition controller
`timescale 1ns/1ps
module tb_pstate_transition_ctrl;
    import pstate_pkg::*;

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic [NCORES-1:0]      core_active = 4'h0;
    logic [NCORES-1:0]      req_we = 4'h0;
    logic [NCORES*8-1:0]    req_ratio = 32'h0;
    logic                   auto_en = 1'b0;
    logic [RATIO_W-1:0]     auto_min = 8'h00;
    logic [RATIO_W-1:0]     auto_max = 8'hff;
    logic [7:0]             activity_window = 8'h00;
    logic [RATIO_W-1:0]     demand_ratio = 8'h08;
    logic [RATIO_W-1:0]     thermal_cap = 8'hff;
    logic                   pll_lock = 1'b1;
    logic [RATIO_W-1:0]     pll_ratio;
    logic                   pll_relock;
    logic [VID_W-1:0]       vid_code;
    logic [RATIO_W-1:0]     applied_ratio;
    logic                   busy;
    int                     error_cnt = 0;
    int                     checked = 0;
    int                     cyc = 0;
    int                     lock_cnt = 0;

    pstate_transition_ctrl DUT (
        .clk             (clk),
        .rst             (rst),
        .core_active     (core_active),
        .req_we          (req_we),
        .req_ratio       (req_ratio),
        .auto_en         (auto_en),
        .auto_min        (auto_min),
        .auto_max        (auto_max),
        .activity_window (activity_window),
        .demand_ratio    (demand_ratio),
        .thermal_cap     (thermal_cap),
        .pll_lock        (pll_lock),
        .pll_ratio       (pll_ratio),
        .pll_relock      (pll_relock),
        .vid_code        (vid_code),
        .applied_ratio   (applied_ratio),
        .busy            (busy)
    );

    always #5 clk = ~clk;

    // Lock drops shortly after handoff and returns ten cycles later
    always @(negedge clk) begin
        if (pll_relock !== 1'b1) lock_cnt <= 0;
        else if (lock_cnt < 30) lock_cnt <= lock_cnt + 1;
        pll_lock <= !(pll_relock === 1'b1 && lock_cnt >= 2 && lock_cnt < 12);
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop();
        if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Independent voltage expectation, saturating at the top code
    function automatic logic [7:0] exp_vid(input logic [7:0] r, input int c);
        int s;
        s = 32 + (r >> 1) + 2 * c;
        return (s > 255) ? 8'hff : s[7:0];
    endfunction : exp_vid

    task automatic wr(input logic [3:0] we, input logic [31:0] data);
        @(negedge clk);
        req_we    = we;
        req_ratio = data;
        @(negedge clk);
        req_we    = 4'h0;
    endtask : wr

    // Follows one transition, judging ramp pacing and the voltage-then-PLL order
    task automatic run_trans(input logic [7:0] er, input logic [7:0] ev, output bit relocked);
        int n;
        int gap;
        int lock_hi;
        logic [7:0] pv;
        n = 0;
        gap = 100;
        lock_hi = 0;
        relocked = 0;
        while (busy !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        cmp("busy_start", 8'h01, {7'h0, busy});
        pv = vid_code;
        while (busy === 1'b1 && n < 4000) begin
            @(negedge clk);
            n++;
            gap++;
            lock_hi = (pll_lock === 1'b1) ? lock_hi + 1 : 0;
            if (vid_code !== pv) begin
                cmp("vid_step", 8'h01, (vid_code > pv) ? vid_code - pv : pv - vid_code);
                cmp("vid_pace", 8'h01, {7'h0, gap >= RAMP_STEP_CYC});
                gap = 0;
                pv = vid_code;
            end
            if (pll_relock === 1'b1 && !relocked) begin
                relocked = 1;
                cmp("vid_before_pll", ev, vid_code);
            end
        end
        cmp("busy_end", 8'h00, {7'h0, busy});
        if (relocked) cmp("lock_seen", 8'h01, {7'h0, lock_hi >= 3});
        cmp("applied_ratio", er, applied_ratio);
        cmp("pll_ratio", er, pll_ratio);
        cmp("vid_code", ev, vid_code);
    endtask : run_trans

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_reset();
        cmp("rst_applied", 8'h08, applied_ratio);
        cmp("rst_vid", 8'h24, vid_code);
        cmp("rst_busy", 8'h00, {7'h0, busy});
        cmp("rst_relock", 8'h00, {7'h0, pll_relock});
    endtask : s_reset

    task automatic s_voltage_only();
        bit rl;
        @(negedge clk);
        core_active = 4'h1;
        run_trans(8'h08, exp_vid(8'h08, 1), rl);
        cmp("no_relock", 8'h00, {7'h0, rl});
    endtask : s_voltage_only

    task automatic s_highest();
        bit rl;
        // Core 0 keeps its request, so only the later activation may move the point
        wr(4'h6, {8'h00, 8'h60, 8'h30, 8'h08});
        @(negedge clk);
        cmp("idle_cores_no_vote", 8'h00, {7'h0, busy});
        core_active = 4'h3;
        run_trans(8'h30, exp_vid(8'h30, 2), rl);
        cmp("relock_used", 8'h01, {7'h0, rl});
    endtask : s_highest

    task automatic s_deferred();
        bit rl;
        wr(4'h2, {16'h0, 8'h20, 8'h00});
        repeat (4) @(negedge clk);
        wr(4'h2, {16'h0, 8'h40, 8'h00});
        run_trans(8'h20, exp_vid(8'h20, 2), rl);
        run_trans(8'h40, exp_vid(8'h40, 2), rl);
    endtask : s_deferred

    task automatic s_inactive();
        bit rl;
        @(negedge clk);
        core_active = 4'h1;
        run_trans(8'h08, exp_vid(8'h08, 1), rl);
    endtask : s_inactive

    task automatic s_auto();
        bit rl;
        @(negedge clk);
        auto_min     = 8'h18;
        auto_max     = 8'h28;
        demand_ratio = 8'h40;
        thermal_cap  = 8'h30;
        @(negedge clk);
        auto_en = 1'b1;
        run_trans(8'h28, exp_vid(8'h28, 1), rl);
        demand_ratio = 8'h04;
        activity_window = 8'h01;
        run_trans(8'h18, exp_vid(8'h18, 1), rl);
        demand_ratio = 8'h40;
        thermal_cap  = 8'h1c;
        run_trans(8'h1c, exp_vid(8'h1c, 1), rl);
        auto_en = 1'b0;
        run_trans(8'h08, exp_vid(8'h08, 1), rl);
    endtask : s_auto

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (12) @(negedge clk);
        s_reset();
        rst = 1'b0;
        repeat (2) @(negedge clk);
        s_voltage_only();
        s_highest();
        s_deferred();
        s_inactive();
        s_auto();
        report_and_stop();
    end

endmodule : tb_pstate_transition_ctrl
